// *** common/xmem_pkg.sv ***
// Constants for the external data access unit and its dual data pointer.
// Assumes a 20 MHz system clock and a special function register port
// driven by the processor core.
package xmem_pkg;

  // ---------------------------------------------------------------
  // Special function register addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_POINTER0_LOW = 8'h82;
  localparam logic [7:0] ADDR_POINTER0_HIGH = 8'h83;
  localparam logic [7:0] ADDR_POINTER1_LOW = 8'h84;
  localparam logic [7:0] ADDR_POINTER1_HIGH = 8'h85;
  localparam logic [7:0] ADDR_POINTER_SELECT = 8'h86;
  localparam logic [7:0] ADDR_TIMING_CONTROL = 8'h8e;

  // ---------------------------------------------------------------
  // Fields and reset values
  // ---------------------------------------------------------------
  localparam int STRETCH_LSB = 0;
  localparam int STRETCH_W = 3;
  localparam logic [2:0] STRETCH_RESET = 3'h1;
  localparam logic [7:0] TIMING_RESET = 8'h01;
  localparam logic [7:0] POINTER_RESET = 8'h00;
  localparam int SCRATCH_BYTES = 256;

  // ---------------------------------------------------------------
  // Machine cycle timing
  // ---------------------------------------------------------------
  localparam int CLK_PER_MC = 4;
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam logic [1:0] PHASE_ALE = 2'h0;
  localparam logic [1:0] PHASE_ADDR = 2'h1;
  // Strobe of the shortest move covers phases 2 and 3 of one cycle.
  localparam logic [1:0] PHASE_STB0 = 2'h2;
  localparam logic [4:0] STROBE_SHORT = 5'h02;
  localparam logic [4:0] STROBE_STEP = 5'h04;

  // Access unit states.
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ADDR,
    ST_STROBE,
    ST_HOLD
  } xstate_t;

endpackage

// *** hw/machine_phase.sv ***
// Four-phase machine cycle sequencer with a last-phase flag.
// Assumes one system clock and a synchronous active-low reset.
`timescale 1ns/100ps
module machine_phase
  import xmem_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic nrst,
  // Phase outputs.
  output logic [1:0] phase,
  output logic cycle_end
);

  logic [1:0] phase_q;
  logic [1:0] phase_d;

  // ---------------------------------------------------------------
  // Phase counter
  // ---------------------------------------------------------------

  // Free-running: fetch rate depends on the clock alone.
  always_comb begin
    phase_d = phase_q + 2'h1; // RULE2
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      phase_q <= PHASE_ALE;
    end else begin
      phase_q <= phase_d;
    end
  end

  assign phase = phase_q;
  assign cycle_end = (phase_q == PHASE_LAST);

endmodule

// *** hw/xdata_unit.sv ***
// External data memory access unit with a stretchable strobe and two
// data pointers. Assumes the core drives the register port and move
// requests synchronously to clk_sys, and that external memory latches
// the low address on the latch pulse.
//
// Behaviour
// RULE1 - Off-chip access via multiplexed port zero/two.
// RULE2 - Fetch rate fixed, four clocks per cycle.
// RULE3 - Stretch field in timing_control bits 2..0.
// RULE4 - Move takes stretch plus two machine cycles.
// RULE5 - Stretch resets to one.
// RULE6 - Strobe 2 clocks, then four per step.
// RULE7 - Stretch lengthens strobe and surrounding timing.
// RULE8 - Stretch never affects program fetch timing.
// RULE9 - Rewritten stretch used by next move.
// RULE10 - First pointer at 82h and 83h.
// RULE11 - Second pointer at 84h and 85h.
// RULE12 - Select bit 86h bit0, others read zero.
// RULE13 - Pointer operations use the selected pointer.
// RULE14 - Incrementing select toggles its low bit.
// RULE15 - Select resets to zero.
// RULE16 - One latch pulse every machine cycle.
// RULE17 - Memory latches address, serves during strobe.
`timescale 1ns/100ps
module xdata_unit
  import xmem_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic nrst,
  // Special function register port.
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_inc,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // Pointer operations from the core.
  input wire logic ptr_load,
  input wire logic [15:0] ptr_load_value,
  input wire logic ptr_inc,
  output logic [15:0] ptr_value,
  // External data move request.
  input wire logic move_req,
  input wire logic move_write,
  input wire logic move_use_ptr,
  input wire logic [7:0] move_short_addr,
  input wire logic [7:0] move_wdata,
  output logic move_busy,
  output logic move_done,
  output logic [7:0] move_rdata,
  // Program fetch address from the core.
  input wire logic [15:0] fetch_addr,
  // External bus pins.
  input wire logic [7:0] port_zero_bus_in,
  output logic [7:0] port_zero_bus_out,
  output logic port_zero_bus_oe,
  output logic [7:0] port_two_high_address,
  output logic addr_latch_en,
  output logic program_fetch_strobe_n,
  output logic read_strobe_n,
  output logic write_strobe_n
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------

  // Strobe width in clocks for a stretch value.
  function automatic logic [4:0] strobe_width(input logic [2:0] s);
    if (s == 3'h0) begin
      strobe_width = STROBE_SHORT;
    end else begin
      strobe_width = 5'(STROBE_STEP * s); // RULE6
    end
  endfunction

  // Read value of a register address, zero when unmapped.
  function automatic logic [7:0] reg_read(
    input logic [7:0] a, input logic [15:0] p0, input logic [15:0] p1,
    input logic sel, input logic [7:0] tc);
    unique case (a)
      ADDR_POINTER0_LOW: reg_read = p0[7:0];
      ADDR_POINTER0_HIGH: reg_read = p0[15:8];
      ADDR_POINTER1_LOW: reg_read = p1[7:0];
      ADDR_POINTER1_HIGH: reg_read = p1[15:8];
      ADDR_POINTER_SELECT: reg_read = {7'h00, sel}; // RULE12
      ADDR_TIMING_CONTROL: reg_read = tc;
      default: reg_read = 8'h00;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Machine cycle sequencer
  // ---------------------------------------------------------------
  logic [1:0] phase;
  logic cycle_end;

  machine_phase u_phase (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .phase(phase),
    .cycle_end(cycle_end)
  );

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [15:0] ptr0_q, ptr0_d, ptr1_q, ptr1_d;
  logic sel_q, sel_d;
  logic [7:0] tc_q, tc_d;
  logic [7:0] rdata_q, rdata_d;
  logic [15:0] active_ptr;
  logic [15:0] ptr_value_q, ptr_value_d;

  assign active_ptr = sel_q ? ptr1_q : ptr0_q; // RULE13

  // Register writes, increments and pointer operations. A load from the
  // core wins over a register write in the same cycle.
  always_comb begin
    ptr0_d = ptr0_q;
    ptr1_d = ptr1_q;
    sel_d = sel_q;
    tc_d = tc_q;
    if (sfr_wr) begin
      unique case (sfr_addr)
        ADDR_POINTER0_LOW: ptr0_d[7:0] = sfr_wdata; // RULE10
        ADDR_POINTER0_HIGH: ptr0_d[15:8] = sfr_wdata; // RULE10
        ADDR_POINTER1_LOW: ptr1_d[7:0] = sfr_wdata; // RULE11
        ADDR_POINTER1_HIGH: ptr1_d[15:8] = sfr_wdata; // RULE11
        ADDR_POINTER_SELECT: sel_d = sfr_wdata[0]; // RULE12
        ADDR_TIMING_CONTROL: tc_d = sfr_wdata; // RULE3 RULE9
        default: ;
      endcase
    end else if (sfr_inc && sfr_addr == ADDR_POINTER_SELECT) begin
      // Carry out of bit 0 is dropped, so an increment just toggles.
      sel_d = ~sel_q; // RULE14
    end
    if (ptr_load) begin
      if (sel_q) ptr1_d = ptr_load_value; // RULE13
      else ptr0_d = ptr_load_value; // RULE13
    end else if (ptr_inc) begin
      if (sel_q) ptr1_d = ptr1_q + 16'h0001; // RULE13
      else ptr0_d = ptr0_q + 16'h0001; // RULE13
    end
    rdata_d = reg_read(sfr_addr, ptr0_q, ptr1_q, sel_q, tc_q);
    // Registered from next values, so the core sees no extra delay.
    ptr_value_d = sel_d ? ptr1_d : ptr0_d; // RULE13
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ptr0_q <= {POINTER_RESET, POINTER_RESET};
      ptr1_q <= {POINTER_RESET, POINTER_RESET};
      sel_q <= 1'b0; // RULE15
      tc_q <= TIMING_RESET; // RULE5
      rdata_q <= 8'h00;
      ptr_value_q <= {POINTER_RESET, POINTER_RESET};
    end else begin
      ptr0_q <= ptr0_d;
      ptr1_q <= ptr1_d;
      sel_q <= sel_d;
      tc_q <= tc_d;
      rdata_q <= rdata_d;
      ptr_value_q <= ptr_value_d;
    end
  end

  assign sfr_rdata = rdata_q;
  assign ptr_value = ptr_value_q;

  // ---------------------------------------------------------------
  // External data move sequencer
  // ---------------------------------------------------------------
  // A move starts at a machine cycle boundary: one address cycle, then
  // a strobe window, then a hold cycle. Stretch s makes the move s+2
  // machine cycles long; the strobe is centred in that span when s is not zero.
  xstate_t st_q, st_d;
  logic pend_q, pend_d;
  logic wr_q, wr_d;
  logic [15:0] addr_q, addr_d;
  logic [7:0] wdat_q, wdat_d;
  logic [2:0] str_q, str_d;
  logic [4:0] cnt_q, cnt_d;
  logic [7:0] mrdata_q, mrdata_d;
  logic done_q, done_d;
  logic busy_q, busy_d;

  always_comb begin
    st_d = st_q;
    pend_d = pend_q;
    wr_d = wr_q;
    addr_d = addr_q;
    wdat_d = wdat_q;
    str_d = str_q;
    cnt_d = cnt_q;
    mrdata_d = mrdata_q;
    done_d = 1'b0;
    unique case (st_q)
      ST_IDLE: begin
        if (move_req && !pend_q) begin
          pend_d = 1'b1;
          wr_d = move_write;
          wdat_d = move_wdata;
          // Short moves keep the high byte from the previous use.
          addr_d = move_use_ptr ? active_ptr
                                : {addr_q[15:8], move_short_addr}; // RULE13
        end
        if (pend_q && cycle_end) begin
          pend_d = 1'b0;
          st_d = ST_ADDR;
          // Stretch sampled now, so a write made before this edge counts.
          str_d = tc_q[STRETCH_LSB +: STRETCH_W]; // RULE9 RULE4
        end
      end
      ST_ADDR: begin
        // Zero stretch starts the strobe mid-cycle; otherwise next cycle.
        if ((str_q == 3'h0 && phase == PHASE_ADDR) ||
            (str_q != 3'h0 && cycle_end)) begin
          st_d = ST_STROBE;
          cnt_d = strobe_width(str_q); // RULE6 RULE7
        end
      end
      ST_STROBE: begin
        cnt_d = cnt_q - 5'h01;
        if (cnt_q == 5'h01) begin
          mrdata_d = port_zero_bus_in; // RULE17
          st_d = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (cycle_end) begin
          st_d = ST_IDLE;
          done_d = 1'b1;
        end
      end
    endcase
    // Busy is registered from the next state so it needs no extra clock.
    busy_d = pend_d || (st_d != ST_IDLE);
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      st_q <= ST_IDLE;
      pend_q <= 1'b0;
      wr_q <= 1'b0;
      addr_q <= 16'h0000;
      wdat_q <= 8'h00;
      str_q <= STRETCH_RESET;
      cnt_q <= 5'h00;
      mrdata_q <= 8'h00;
      done_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      st_q <= st_d;
      pend_q <= pend_d;
      wr_q <= wr_d;
      addr_q <= addr_d;
      wdat_q <= wdat_d;
      str_q <= str_d;
      cnt_q <= cnt_d;
      mrdata_q <= mrdata_d;
      done_q <= done_d;
      busy_q <= busy_d;
    end
  end

  // ---------------------------------------------------------------
  // Pin drive
  // ---------------------------------------------------------------
  // Every pin but the fetch address is registered from next values, so pins line up with the internal phase.
  logic in_move;
  logic nxt_strobe;
  logic [7:0] p0_d, p2_d;
  logic p0_oe_d, ale_d, program_fetch_strobe_d;
  logic rd_d, wrs_d;

  assign in_move = (st_d != ST_IDLE);
  assign nxt_strobe = (st_d == ST_STROBE);

  always_comb begin
    ale_d = (phase_d_of(phase) == PHASE_ALE); // RULE16
    rd_d = !(nxt_strobe && !wr_d); // RULE6 RULE17
    wrs_d = !(nxt_strobe && wr_d); // RULE6 RULE17
    if (in_move) begin
      // Data cycles: no fetch strobe; address then data on port zero.
      program_fetch_strobe_d = 1'b1; // RULE8
      p2_d = addr_d[15:8]; // RULE1
      p0_d = nxt_strobe ? wdat_d : addr_d[7:0]; // RULE1
      p0_oe_d = !nxt_strobe || wr_d;
    end else begin
      // Fetch cycles keep the fixed four-clock rhythm.
      program_fetch_strobe_d = !(phase_d_of(phase) == PHASE_STB0 ||
                 phase_d_of(phase) == PHASE_LAST); // RULE2 RULE8
      p2_d = fetch_addr[15:8]; // RULE1
      p0_d = fetch_addr[7:0];
      p0_oe_d = (phase_d_of(phase) == PHASE_ALE ||
                 phase_d_of(phase) == PHASE_ADDR);
    end
  end

  function automatic logic [1:0] phase_d_of(input logic [1:0] p);
    phase_d_of = p + 2'h1;
  endfunction

  logic [7:0] p0_q, p2_q;
  logic p0_oe_q, ale_q, program_fetch_strobe_q, rd_q, wrs_q;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      p0_q <= 8'h00;
      p2_q <= 8'h00;
      p0_oe_q <= 1'b0;
      ale_q <= 1'b0;
      program_fetch_strobe_q <= 1'b1;
      rd_q <= 1'b1;
      wrs_q <= 1'b1;
    end else begin
      p0_q <= p0_d;
      p2_q <= p2_d;
      p0_oe_q <= p0_oe_d;
      ale_q <= ale_d;
      program_fetch_strobe_q <= program_fetch_strobe_d;
      rd_q <= rd_d;
      wrs_q <= wrs_d;
    end
  end

  assign port_zero_bus_out = p0_q;
  assign port_zero_bus_oe = p0_oe_q;
  assign port_two_high_address = p2_q;
  assign addr_latch_en = ale_q;
  assign program_fetch_strobe_n = program_fetch_strobe_q;
  assign read_strobe_n = rd_q;
  assign write_strobe_n = wrs_q;
  assign move_busy = busy_q;
  assign move_done = done_q;
  assign move_rdata = mrdata_q;

endmodule

// *** sim/xdata_unit_chk.sv ***
// Port checker for the external data unit.
// Assumes one clock domain; bound to the unit below.
`timescale 1ns/100ps
module xdata_unit_chk
  import xmem_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic nrst,
  // Register and pointer side.
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_inc,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic ptr_load,
  input wire logic ptr_inc,
  input wire logic [15:0] ptr_value,
  // Move handshake and pins.
  input wire logic move_busy,
  input wire logic move_done,
  input wire logic port_zero_bus_oe,
  input wire logic addr_latch_en,
  input wire logic program_fetch_strobe_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n
);
  // ---------------------------------------------------------------
  // Helper state
  // ---------------------------------------------------------------
  logic [2:0] st_q, st_d;
  logic [4:0] lo_q, lo_d, w_exp;
  logic idle;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // Shadow of the stretch field; writes only land between moves here.
  assign idle = read_strobe_n && write_strobe_n;
  assign w_exp = (st_q == 3'h0) ? STROBE_SHORT : {st_q, 2'b00};
  always_comb begin
    st_d = st_q;
    if (sfr_wr && sfr_addr == ADDR_TIMING_CONTROL) begin
      st_d = sfr_wdata[2:0];
    end
    lo_d = idle ? 5'h00 : lo_q + 5'h01;
  end
  // Registers of the shadow and of the strobe-width count.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      st_q <= STRETCH_RESET;
      lo_q <= 5'h00;
    end else begin
      st_q <= st_d;
      lo_q <= lo_d;
    end
  end
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  sequence s_ale_gap;
    !addr_latch_en [*3] ##1 addr_latch_en;
  endsequence
  sequence s_fetch;
    !program_fetch_strobe_n ##1 program_fetch_strobe_n;
  endsequence
  property p_ale; addr_latch_en |=> s_ale_gap; endproperty
  property p_width; $rose(idle) |-> lo_q == w_exp; endproperty
  property p_excl;
    !read_strobe_n |-> write_strobe_n && program_fetch_strobe_n;
  endproperty
  property p_wr_drive; !write_strobe_n |-> port_zero_bus_oe; endproperty
  property p_rd_free; !read_strobe_n |-> !port_zero_bus_oe; endproperty
  property p_len;
    $rose(move_busy) |-> (!move_done) [*6] ##[1:35] move_done;
  endproperty
  property p_done; move_done |=> !move_done; endproperty
  property p_sel;
    sfr_addr == ADDR_POINTER_SELECT |=> sfr_rdata[7:1] == 7'h00;
  endproperty
  property p_inc;
    ptr_inc && !ptr_load && !sfr_wr && !sfr_inc |=>
      ptr_value == $past(ptr_value) + 16'h0001;
  endproperty
  property p_fetch; $fell(program_fetch_strobe_n) |=> s_fetch; endproperty
  a_ale: assert property (p_ale) else $error("latch pulse gap");
  a_width: assert property (p_width) else $error("strobe width");
  a_excl: assert property (p_excl) else $error("strobe overlap");
  a_wr_drive: assert property (p_wr_drive) else $error("no wr data");
  a_rd_free: assert property (p_rd_free) else $error("rd drive");
  a_len: assert property (p_len) else $error("move length");
  a_done: assert property (p_done) else $error("done width");
  a_sel: assert property (p_sel) else $error("select bits");
  a_inc: assert property (p_inc) else $error("pointer inc");
  a_fetch: assert property (p_fetch) else $error("fetch strobe");
endmodule
bind xdata_unit xdata_unit_chk xdata_unit_chk_inst (.clk_sys, .nrst,
  .sfr_addr, .sfr_wr, .sfr_inc, .sfr_wdata, .sfr_rdata, .ptr_load,
  .ptr_inc, .ptr_value, .move_busy, .move_done, .port_zero_bus_oe,
  .addr_latch_en, .program_fetch_strobe_n, .read_strobe_n,
  .write_strobe_n);

// *** sim/ext_sram_model.sv ***
// Behavioural external RAM on the multiplexed bus.
// Assumes registered pins that change just after clk_sys edges.
`timescale 1ns/100ps
module ext_sram_model (
  // Clock and speed mode.
  input wire logic clk_sys,
  input wire logic slow,
  // Bus pins.
  input wire logic [7:0] port_zero_bus_out,
  input wire logic [7:0] port_two_high_address,
  input wire logic addr_latch_en,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  output logic [7:0] port_zero_bus_in
);
  logic [7:0] mem [0:65535];
  logic [7:0] lo = 8'h00, last = 8'h00;
  logic [15:0] last_addr = 16'h0000;
  int cnt = 0;
  // Latch the low byte only outside a strobe, as a real latch would hold.
  always @(posedge clk_sys) begin
    if (addr_latch_en && read_strobe_n && write_strobe_n) begin
      lo <= port_zero_bus_out;
    end
    cnt <= read_strobe_n ? 0 : cnt + 1;
    last <= port_zero_bus_in;
    if (!write_strobe_n) begin
      mem[{port_two_high_address, lo}] <= port_zero_bus_out;
      last_addr <= {port_two_high_address, lo};
    end
  end
  // A slow part answers after six strobe clocks; else the bus flips.
  assign port_zero_bus_in = (!read_strobe_n && (!slow || cnt >= 6)) ?
    mem[{port_two_high_address, lo}] : ~last;
endmodule

// *** sim/stretched_xdata_dual_pointer_tb.sv ***
// Self-checking bench for the external data unit and its two pointers.
// Assumes the package, the checker and the RAM model compile first.
`timescale 1ns/100ps
module stretched_xdata_dual_pointer_tb;
  import xmem_pkg::*;
  logic clk_sys = 1'b0, nrst = 1'b0, sfr_wr = 1'b0, sfr_inc = 1'b0;
  logic ptr_load = 1'b0, ptr_inc = 1'b0, move_req = 1'b0, slow = 1'b0;
  logic move_write = 1'b0, move_use_ptr = 1'b1;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, move_wdata = 8'h00;
  logic [7:0] move_short_addr = 8'h00, sfr_rdata, move_rdata;
  logic [7:0] port_zero_bus_in, port_zero_bus_out, port_two_high_address;
  logic [15:0] ptr_load_value = 16'h0000, fetch_addr = 16'h4321;
  logic [15:0] ptr_value;
  logic move_busy, move_done, port_zero_bus_oe, addr_latch_en;
  logic program_fetch_strobe_n, read_strobe_n, write_strobe_n;
  int fail_count = 0, comparisons = 0, cycles = 0, n;
  xdata_unit xdata_unit_inst (.clk_sys, .nrst, .sfr_addr, .sfr_wr,
    .sfr_inc, .sfr_wdata, .sfr_rdata, .ptr_load, .ptr_load_value,
    .ptr_inc, .ptr_value, .move_req, .move_write, .move_use_ptr,
    .move_short_addr, .move_wdata, .move_busy, .move_done, .move_rdata,
    .fetch_addr, .port_zero_bus_in, .port_zero_bus_out, .port_zero_bus_oe,
    .port_two_high_address, .addr_latch_en, .program_fetch_strobe_n,
    .read_strobe_n, .write_strobe_n);
  ext_sram_model ext_sram_model_inst (.clk_sys, .slow, .port_zero_bus_out,
    .port_two_high_address, .addr_latch_en, .read_strobe_n,
    .write_strobe_n, .port_zero_bus_in);
  // ---------------------------------------------------------------
  // Clock, watchdog and shared tasks
  // ---------------------------------------------------------------
  initial forever #25 clk_sys = ~clk_sys;
  // The whole run needs well under a thousand cycles.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic step(int k = 1);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(logic [15:0] seen, logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic do_reset();
    nrst = 1'b0;
    step(4);
    nrst = 1'b1;
  endtask
  // Register write, or an increment when inc is set.
  task automatic wr(logic [7:0] a, logic [7:0] d, logic inc = 1'b0);
    step();
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = !inc;
    sfr_inc = inc;
    step();
    sfr_wr = 1'b0;
    sfr_inc = 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    step();
    sfr_addr = a;
    step();
    chk(16'(sfr_rdata), 16'(e));
  endtask
  // One data move; n counts cycles from the request to the done pulse.
  task automatic xmove(logic w, logic [7:0] d);
    step();
    move_write = w;
    move_wdata = d;
    move_req = 1'b1;
    step();
    move_req = 1'b0;
    chk(16'(move_busy), 16'h0001);
    n = 1;
    while (move_done !== 1'b1 && n < 60) begin
      step();
      n++;
    end
    chk(16'({move_done, move_busy}), 16'h0002);
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    rd(ADDR_TIMING_CONTROL, TIMING_RESET);
    rd(ADDR_POINTER_SELECT, 8'h00);
    rd(ADDR_POINTER0_HIGH, POINTER_RESET);
    rd(ADDR_POINTER1_LOW, POINTER_RESET);
    rd(8'h87, 8'h00);
    repeat (8) if (addr_latch_en !== 1'b1) step();
    chk(16'(addr_latch_en), 16'h0001);
    chk(16'(port_zero_bus_out), 16'h0021);
    step(2);
    chk(16'(program_fetch_strobe_n), 16'h0000);
    chk(16'(port_zero_bus_oe), 16'h0000);
    chk(16'(port_two_high_address), 16'h0043);
  endtask
  task automatic t_regs();
    wr(ADDR_POINTER0_LOW, 8'h34);
    wr(ADDR_POINTER0_HIGH, 8'h12);
    wr(ADDR_POINTER1_LOW, 8'hcd);
    wr(ADDR_POINTER1_HIGH, 8'hab);
    chk(ptr_value, 16'h1234);
    wr(ADDR_POINTER_SELECT, 8'hff);
    chk(ptr_value, 16'habcd);
    rd(ADDR_POINTER_SELECT, 8'h01);
    wr(ADDR_POINTER_SELECT, 8'h00, 1'b1);
    chk(ptr_value, 16'h1234);
    wr(ADDR_POINTER_SELECT, 8'h00, 1'b1);
    ptr_load_value = 16'h00ff;
    ptr_load = 1'b1;
    step();
    ptr_load = 1'b0;
    ptr_inc = 1'b1;
    step();
    ptr_inc = 1'b0;
    rd(ADDR_POINTER1_HIGH, 8'h01);
    rd(ADDR_POINTER0_LOW, 8'h34);
    wr(ADDR_POINTER_SELECT, 8'h00, 1'b1);
  endtask
  // Every stretch value, rewritten between moves, with a write and a read.
  task automatic t_stretch();
    for (int s = 0; s < 8; s++) begin
      wr(ADDR_TIMING_CONTROL, 8'(s));
      rd(ADDR_TIMING_CONTROL, 8'(s));
      xmove(1'b1, 8'h50 + 8'(s));
      chk(16'(n >= 4 * s + 9 && n <= 4 * s + 13), 16'h0001);
      chk(16'(ext_sram_model_inst.mem[16'h1234]), 16'h50 + 16'(s));
      xmove(1'b0, 8'h00);
      chk(16'(move_rdata), 16'h50 + 16'(s));
    end
  endtask
  task automatic t_slow_short();
    slow = 1'b1;
    wr(ADDR_TIMING_CONTROL, 8'h02);
    xmove(1'b0, 8'h00);
    chk(16'(move_rdata), 16'h0057);
    slow = 1'b0;
    move_use_ptr = 1'b0;
    move_short_addr = 8'h77;
    xmove(1'b1, 8'h3c);
    chk(16'(ext_sram_model_inst.last_addr[7:0]), 16'h0077);
    move_use_ptr = 1'b1;
    xmove(1'b1, 8'h11);
    chk(16'(ext_sram_model_inst.mem[16'h1234]), 16'h0011);
  endtask
  initial begin
    do_reset();
    t_reset();
    t_regs();
    t_stretch();
    t_slow_short();
    do_reset();
    t_reset();
    stop_test();
  end
endmodule
